/* File: src/acc_control.sv */
// control register, serial port and calibration sequencer
// assumes the host keeps read and write frames apart and clocks bits
// slower than a few system clocks (bench sclk period 160 ns)
module acc_control (
   // clock and reset
   input  wire logic              CLOCK,
   input  wire logic              RST,
   // serial port pins
   input  wire logic              SCLK,
   input  wire logic              TFS_N,
   input  wire logic              RFS_N,
   input  wire logic              REG_TARGET_PIN,
   input  wire logic              SDATA_I,
   output logic                   SDATA_O,
   output logic                   SDATA_OE_N,
   output logic                   RESULT_READY_N,
   // filter side
   input  wire logic [23:0]       CONV_WORD,
   input  wire logic              CONV_DONE,
   // front end controls
   output acc_pkg::acc_ctl_t      CTRL,
   output logic [7:0]             GAIN_FACTOR,
   output logic                   CAL_BUSY,
   output logic [2:0]             CAL_KIND,
   output logic                   BG_CAL_SLOT
);

   typedef struct packed {
      acc_pkg::acc_pins_t p1;
      acc_pkg::acc_pins_t p2;
      acc_pkg::acc_pins_t p3;
      acc_pkg::acc_ctl_t  ctl;
      logic [1:0][23:0]   zs;
      logic [1:0][23:0]   fs;
      logic [23:0]        dreg;
      logic [23:0]        shreg;
      logic [4:0]         cnt;
      logic [4:0]         rdlen;
      logic               rd_data;
      acc_pkg::acc_seq_t  seq;
      logic [2:0]         kind;
      logic [11:0]        calcnt;
      logic [2:0]         bgcnt;
      logic               bg_slot;
      logic               result_ready_n_n;
      logic               sd_o;
      logic               sd_oe_n;
      logic [7:0]         gain;
   } acc_state_t;

   acc_state_t st_reg;
   acc_state_t st_next;

   logic sclk_rise, sclk_fall, tfs_fall, tfs_rise, rfs_fall, rfs_rise;
   logic wr_commit, cal_done, a0;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_next    = st_reg;
      // first stage feeds only the second
      st_next.p1 = '{SCLK, TFS_N, RFS_N, SDATA_I, REG_TARGET_PIN};
      st_next.p2 = st_reg.p1;
      st_next.p3 = st_reg.p2;
      a0         = st_reg.p2.reg_target_pin;
      sclk_rise  = st_reg.p2.sclk & ~st_reg.p3.sclk;
      sclk_fall  = ~st_reg.p2.sclk & st_reg.p3.sclk;
      tfs_fall   = ~st_reg.p2.tfs_n & st_reg.p3.tfs_n;
      tfs_rise   = st_reg.p2.tfs_n & ~st_reg.p3.tfs_n;
      rfs_fall   = ~st_reg.p2.rfs_n & st_reg.p3.rfs_n;
      rfs_rise   = st_reg.p2.rfs_n & ~st_reg.p3.rfs_n;
      // short frames never reach a register
      wr_commit  = tfs_rise && st_reg.cnt == acc_pkg::FULL_LEN;
      cal_done   = st_reg.seq == acc_pkg::SEQ_CAL &&
                   st_reg.calcnt == acc_pkg::CAL_STEP_CYCLES - 12'h001;
      st_next.bg_slot = 1'b0;

      // write frame: extra clocks past 24 are ignored
      if (tfs_fall) begin
         st_next.cnt = '0;
      end else if (!st_reg.p2.tfs_n && sclk_rise &&
                   st_reg.cnt != acc_pkg::FULL_LEN) begin
         st_next.shreg = {st_reg.shreg[22:0], st_reg.p2.sdata};
         st_next.cnt   = st_reg.cnt + 5'h01;
      end

      // read frame
      if (rfs_fall) begin
         st_next.cnt     = '0;
         st_next.sd_oe_n = 1'b0;
         st_next.rdlen   = acc_pkg::FULL_LEN;
         st_next.rd_data = 1'b0;
         if (!a0) begin
            st_next.shreg = st_reg.ctl;
         end else begin
            unique case (st_reg.ctl.op_mode_sel)
               acc_pkg::MODE_ZS_COEF:
                  st_next.shreg = st_reg.zs[st_reg.ctl.input_pick];
               acc_pkg::MODE_FS_COEF:
                  st_next.shreg = st_reg.fs[st_reg.ctl.input_pick];
               default: begin
                  st_next.shreg   = st_reg.dreg;
                  st_next.rd_data = 1'b1;
                  st_next.rdlen   = st_reg.ctl.result_width_sel ?
                                    acc_pkg::FULL_LEN :
                                    acc_pkg::SHORT_LEN;
               end
            endcase
         end
         st_next.sd_o = st_next.shreg[23];
      end else if (!st_reg.sd_oe_n && (rfs_rise || (sclk_fall &&
                   st_reg.cnt + 5'h01 == st_reg.rdlen))) begin
         st_next.sd_oe_n = 1'b1;
         if (st_reg.rd_data && !rfs_rise) begin
            st_next.result_ready_n_n = 1'b1;
         end
      end else if (!st_reg.sd_oe_n && sclk_fall) begin
         st_next.shreg = {st_reg.shreg[22:0], 1'b0};
         st_next.sd_o  = st_reg.shreg[22];
         st_next.cnt   = st_reg.cnt + 5'h01;
      end

      // conversion results; background mode keeps one word in six
      if (CONV_DONE && st_reg.seq == acc_pkg::SEQ_IDLE) begin
         if (st_reg.ctl.op_mode_sel == acc_pkg::MODE_BACKGND) begin
            st_next.bgcnt = (st_reg.bgcnt == acc_pkg::BG_RATIO - 3'h1) ?
                            3'h0 : st_reg.bgcnt + 3'h1;
            st_next.bg_slot = st_reg.bgcnt != acc_pkg::BG_RATIO - 3'h1;
         end
         if (st_reg.ctl.op_mode_sel != acc_pkg::MODE_BACKGND ||
             st_reg.bgcnt == acc_pkg::BG_RATIO - 3'h1) begin
            st_next.dreg   = CONV_WORD;
            st_next.result_ready_n_n = 1'b0;
         end
      end

      // calibration sequencer
      unique case (st_reg.seq)
         acc_pkg::SEQ_IDLE: st_next.calcnt = '0;
         acc_pkg::SEQ_CAL: begin
            st_next.calcnt = st_reg.calcnt + 12'h001;
            if (cal_done) begin
               st_next.seq             = acc_pkg::SEQ_IDLE;
               st_next.ctl.op_mode_sel = acc_pkg::MODE_NORMAL;
               st_next.result_ready_n_n          = 1'b0;
            end
         end
      endcase

      // register writes win over a finishing calibration
      if (wr_commit && !a0) begin
         st_next.ctl   = st_reg.shreg;
         st_next.bgcnt = '0;
         if (st_reg.shreg[23:21] inside {acc_pkg::MODE_SELF_CAL,
             acc_pkg::MODE_SYS_ZERO, acc_pkg::MODE_SYS_FULL,
             acc_pkg::MODE_SYS_OFS}) begin
            st_next.seq    = acc_pkg::SEQ_CAL;
            st_next.kind   = st_reg.shreg[23:21];
            st_next.calcnt = '0;
            st_next.result_ready_n_n = 1'b1;
         end
      end else if (wr_commit) begin
         if (st_reg.ctl.op_mode_sel == acc_pkg::MODE_ZS_COEF) begin
            st_next.zs[st_reg.ctl.input_pick] = st_reg.shreg;
         end
         if (st_reg.ctl.op_mode_sel == acc_pkg::MODE_FS_COEF) begin
            st_next.fs[st_reg.ctl.input_pick] = st_reg.shreg;
         end
      end
      st_next.gain = 8'h01 << st_next.ctl.amp_gain_code;
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         st_reg         <= '0;
         st_reg.p1      <= acc_pkg::PINS_IDLE;
         st_reg.p2      <= acc_pkg::PINS_IDLE;
         st_reg.p3      <= acc_pkg::PINS_IDLE;
         st_reg.ctl     <= acc_pkg::CTL_RESET;
         st_reg.seq     <= acc_pkg::SEQ_IDLE;
         st_reg.result_ready_n_n  <= 1'b1;
         st_reg.sd_oe_n <= 1'b1;
         st_reg.gain    <= 8'h01;
      end else begin
         st_reg <= st_next;
      end
   end

   assign SDATA_O        = st_reg.sd_o;
   assign SDATA_OE_N     = st_reg.sd_oe_n;
   assign RESULT_READY_N = st_reg.result_ready_n_n;
   assign CTRL           = st_reg.ctl;
   assign GAIN_FACTOR    = st_reg.gain;
   assign CAL_BUSY       = st_reg.seq[1];
   assign CAL_KIND       = st_reg.kind;
   assign BG_CAL_SLOT    = st_reg.bg_slot;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   property p_reset_defaults;
      @(posedge CLOCK) $past(RST) |-> CTRL == '0 && GAIN_FACTOR == 8'h01
         && RESULT_READY_N;
   endproperty
   a_reset_defaults: assert property (p_reset_defaults)
      else $error("control defaults wrong after reset");

   property p_ctl_load;
      @(posedge CLOCK) disable iff (RST)
         wr_commit && !a0 && !cal_done |=> CTRL == $past(st_reg.shreg);
   endproperty
   a_ctl_load: assert property (p_ctl_load)
      else $error("control word not loaded");

   property p_self_done;
      @(posedge CLOCK) disable iff (RST)
         cal_done && st_reg.kind == acc_pkg::MODE_SELF_CAL && !wr_commit
         |=> CTRL.op_mode_sel == acc_pkg::MODE_NORMAL && !RESULT_READY_N;
   endproperty
   a_self_done: assert property (p_self_done)
      else $error("self calibration did not finish cleanly");

   property p_cal_hold;
      @(posedge CLOCK) disable iff (RST)
         $rose(CAL_BUSY) |-> CAL_BUSY[*8] ##0 RESULT_READY_N;
   endproperty
   a_cal_hold: assert property (p_cal_hold)
      else $error("calibration step ended too early");

   property p_full_done;
      @(posedge CLOCK) disable iff (RST)
         CAL_BUSY && CAL_KIND == acc_pkg::MODE_SYS_FULL && cal_done
         |=> !CAL_BUSY ##0 !RESULT_READY_N;
   endproperty
   a_full_done: assert property (p_full_done)
      else $error("full-scale step did not flag ready");

   // busy cycles of the current step; a step-starting write restarts it
   logic [11:0] busy_run;
   logic        cal_start;
   assign cal_start = wr_commit && !a0 && st_reg.shreg[23:21] inside
                      {acc_pkg::MODE_SELF_CAL, acc_pkg::MODE_SYS_ZERO,
                       acc_pkg::MODE_SYS_FULL, acc_pkg::MODE_SYS_OFS};
   always_ff @(posedge CLOCK) begin
      if (RST || !CAL_BUSY || cal_start) begin
         busy_run <= '0;
      end else begin
         busy_run <= busy_run + 12'h001;
      end
   end

   property p_ofs_len;
      @(posedge CLOCK) disable iff (RST)
         $fell(CAL_BUSY) && CAL_KIND == acc_pkg::MODE_SYS_OFS
         |-> busy_run == acc_pkg::CAL_STEP_CYCLES;
   endproperty
   a_ofs_len: assert property (p_ofs_len)
      else $error("offset step length wrong");

   property p_bg_skip;
      @(posedge CLOCK) disable iff (RST)
         CONV_DONE && !CAL_BUSY && st_reg.bgcnt != 3'h5 &&
         CTRL.op_mode_sel == acc_pkg::MODE_BACKGND |=> $stable(st_reg.dreg);
   endproperty
   a_bg_skip: assert property (p_bg_skip)
      else $error("background mode kept a calibration slot");

   property p_zs_write;
      @(posedge CLOCK) disable iff (RST)
         wr_commit && a0 && CTRL.op_mode_sel == acc_pkg::MODE_ZS_COEF
         |=> st_reg.zs[CTRL.input_pick] == $past(st_reg.shreg);
   endproperty
   a_zs_write: assert property (p_zs_write)
      else $error("zero-scale coefficient not written");

   property p_short_write;
      @(posedge CLOCK) disable iff (RST)
         tfs_rise && st_reg.cnt != acc_pkg::FULL_LEN
         |=> $stable(st_reg.fs) && $stable(CTRL);
   endproperty
   a_short_write: assert property (p_short_write)
      else $error("short frame changed a register");

   property p_gain;
      @(posedge CLOCK) disable iff (RST)
         GAIN_FACTOR == (8'h01 << CTRL.amp_gain_code);
   endproperty
   a_gain: assert property (p_gain)
      else $error("gain factor mismatch");

   property p_width;
      @(posedge CLOCK) disable iff (RST)
         rfs_fall && a0 && CTRL.op_mode_sel == acc_pkg::MODE_NORMAL
         |=> st_reg.rdlen == (CTRL.result_width_sel ? 5'h18 : 5'h10);
   endproperty
   a_width: assert property (p_width)
      else $error("read length ignores width bit");

   property p_mode_zero;
      @(posedge CLOCK) disable iff (RST)
         $fell(CAL_BUSY) && !$past(wr_commit)
         |-> CTRL.op_mode_sel == acc_pkg::MODE_NORMAL;
   endproperty
   a_mode_zero: assert property (p_mode_zero)
      else $error("mode field not cleared after calibration");

   c_self_cal: cover property (@(posedge CLOCK) disable iff (RST)
      $fell(CAL_BUSY) && CAL_KIND == acc_pkg::MODE_SELF_CAL);
   c_bg_word: cover property (@(posedge CLOCK) disable iff (RST)
      CTRL.op_mode_sel == acc_pkg::MODE_BACKGND && $fell(RESULT_READY_N));
   c_coef_rd: cover property (@(posedge CLOCK) disable iff (RST)
      rfs_fall && a0 && CTRL.op_mode_sel == acc_pkg::MODE_FS_COEF);

endmodule : acc_control

/* File: src/acc_pkg.sv */
// shared constants and carriers for the converter control block
// assumes one 125 MHz clock domain; serial pins come in unsynchronised
package acc_pkg;

   // ----------------------------------------------------------------
   // control word layout, msb first
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [2:0]  op_mode_sel;
      logic [2:0]  amp_gain_code;
      logic        input_pick;
      logic        sleep_request;
      logic        result_width_sel;
      logic        excitation_on;
      logic        open_sensor_current;
      logic        polarity_uni;
      logic [11:0] notch_code;
   } acc_ctl_t;

   localparam int          WORD_BITS      = 24;
   localparam logic [4:0]  FULL_LEN       = 5'h18;
   localparam logic [4:0]  SHORT_LEN      = 5'h10;
   localparam acc_ctl_t    CTL_RESET      = '0;

   // ----------------------------------------------------------------
   // operating modes
   // ----------------------------------------------------------------
   localparam logic [2:0]  MODE_NORMAL    = 3'h0;
   localparam logic [2:0]  MODE_SELF_CAL  = 3'h1;
   localparam logic [2:0]  MODE_SYS_ZERO  = 3'h2;
   localparam logic [2:0]  MODE_SYS_FULL  = 3'h3;
   localparam logic [2:0]  MODE_SYS_OFS   = 3'h4;
   localparam logic [2:0]  MODE_BACKGND   = 3'h5;
   localparam logic [2:0]  MODE_ZS_COEF   = 3'h6;
   localparam logic [2:0]  MODE_FS_COEF   = 3'h7;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam logic [11:0] CAL_STEP_CYCLES = 12'h400;
   localparam logic [2:0]  BG_RATIO        = 3'h6;

   // ----------------------------------------------------------------
   // serial pin bundle as sampled
   // ----------------------------------------------------------------
   typedef struct packed {
      logic sclk;
      logic tfs_n;
      logic rfs_n;
      logic sdata;
      logic reg_target_pin;
   } acc_pins_t;

   localparam acc_pins_t PINS_IDLE = 5'h0e;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b01,
      SEQ_CAL  = 2'b10
   } acc_seq_t;

endpackage : acc_pkg

/* File: verification/acc_host_model.sv */
// host model: bit-bangs the serial port of the control block
// assumes the bench calls its task from one process at a time
module acc_host_model (
   // clock
   input  wire logic CLOCK,
   // serial port
   output logic      SCLK,
   output logic      TFS_N,
   output logic      RFS_N,
   output logic      REG_TARGET_PIN,
   output logic      SDATA_I,
   input  wire logic SDATA_W
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      SCLK           = 1'b0;
      TFS_N          = 1'b1;
      RFS_N          = 1'b1;
      REG_TARGET_PIN = 1'b0;
      SDATA_I        = 1'b1;
   end

   // half of a 160 ns serial period
   task automatic half();
      repeat (10) @(posedge CLOCK);
   endtask : half

   // one frame; the serial clock stands low outside it
   task automatic xfer(input logic a0, input logic rd,
                       input logic [23:0] wdat, input int n,
                       output logic [23:0] rdat);
      rdat = '0;
      @(posedge CLOCK);
      REG_TARGET_PIN <= a0;
      RFS_N          <= ~rd;
      TFS_N          <= rd;
      for (int i = 0; i < n; i++) begin
         if (!rd) SDATA_I <= wdat[23-i];
         half();
         SCLK <= 1'b1;
         rdat = {rdat[22:0], SDATA_W};
         half();
         SCLK <= 1'b0;
      end
      half();
      TFS_N   <= 1'b1;
      RFS_N   <= 1'b1;
      // released line must not keep showing the last bit
      SDATA_I <= ~SDATA_I;
      half();
   endtask : xfer

endmodule : acc_host_model

/* File: verification/test_acc_control.sv */
// bench for the control block: table of control words, then calibration,
// coefficient, conversion and background cases
// assumes acc_pkg is compiled first; 125 MHz clock, host serial at 160 ns
module test_acc_control;
   timeunit 1ns;
   timeprecision 1ps;

   logic               clock, rst, conv_done, sd_o, sd_oe_n, ready_n;
   logic               sclk, tfs_n, rfs_n, a0, host_sd, sdata_w;
   logic               busy, bg_slot;
   logic [23:0]        conv_word, rdat;
   logic [7:0]         gain;
   logic [2:0]         kind;
   acc_pkg::acc_ctl_t  ctrl;
   int                 err_total, num_checks, cycles, slots, n0;

   typedef struct packed {
      logic [23:0] word;
      logic [7:0]  gain;
   } acc_row_t;
   // notch codes kept within 19..2000
   acc_row_t rows [8] = '{
      '{24'h000013, 8'h01}, '{24'ha607d0, 8'h02},
      '{24'hc90100, 8'h04}, '{24'hec83e8, 8'h08},
      '{24'h104014, 8'h10}, '{24'hb427cf, 8'h20},
      '{24'hd81055, 8'h40}, '{24'h1ff200, 8'h80}};

   assign sdata_w = (sd_oe_n === 1'b0) ? sd_o : host_sd;

   acc_control i_acc_control (
      .CLOCK(clock), .RST(rst), .SCLK(sclk), .TFS_N(tfs_n),
      .RFS_N(rfs_n), .REG_TARGET_PIN(a0), .SDATA_I(sdata_w),
      .SDATA_O(sd_o), .SDATA_OE_N(sd_oe_n), .RESULT_READY_N(ready_n),
      .CONV_WORD(conv_word), .CONV_DONE(conv_done), .CTRL(ctrl),
      .GAIN_FACTOR(gain), .CAL_BUSY(busy), .CAL_KIND(kind),
      .BG_CAL_SLOT(bg_slot));

   acc_host_model i_acc_host_model (
      .CLOCK(clock), .SCLK(sclk), .TFS_N(tfs_n), .RFS_N(rfs_n),
      .REG_TARGET_PIN(a0), .SDATA_I(host_sd), .SDATA_W(sdata_w));

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   always @(posedge clock) begin
      cycles++;
      if (bg_slot === 1'b1) slots++;
      if (cycles == 40000) begin
         err_total++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : report_and_stop

   task automatic chk(input string what, input logic [23:0] exp,
                      input logic [23:0] got);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic xfer(input logic a, input logic rd, input logic [23:0] w,
                       input int n);
      i_acc_host_model.xfer(a, rd, w, n, rdat);
      @(negedge clock);
   endtask : xfer

   task automatic conv(input logic [23:0] w);
      @(posedge clock);
      conv_word <= w;
      conv_done <= 1'b1;
      @(posedge clock);
      conv_done <= 1'b0;
      repeat (2) @(posedge clock);
      @(negedge clock);
   endtask : conv

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst       = 1'b1;
      conv_done = 1'b0;
      conv_word = '0;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk("ctrl reset", 24'h000000, ctrl);
      chk("gain reset", 24'h000001, gain);
      chk("ready reset", 24'h000001, ready_n);
      chk("oe reset", 24'h000001, sd_oe_n);
      for (int r = 0; r < 8; r++) begin
         xfer(1'b0, 1'b0, rows[r].word, 24);
         chk("ctrl", rows[r].word, ctrl);
         chk("gain", rows[r].gain, gain);
         xfer(1'b0, 1'b1, 24'h0, 24);
         chk("ctrl read", rows[r].word, rdat);
         chk("oe released", 24'h000001, sd_oe_n);
      end
      xfer(1'b0, 1'b0, 24'h2a5000, 23);
      chk("short write", 24'h1ff200, ctrl);
      // calibration steps, host waits for ready each time
      for (int m = 1; m <= 4; m++) begin
         xfer(1'b0, 1'b0, {m[2:0], 21'h0a0064}, 24);
         chk("busy", 24'h000001, busy);
         n0 = 0;
         while (ready_n !== 1'b0 && n0 < 1100) begin
            @(negedge clock);
            n0++;
         end
         chk("ready", 24'h000000, ready_n);
         chk("mode cleared", 24'h0a0064, ctrl);
         chk("kind", {21'h0, m[2:0]}, kind);
         xfer(1'b0, 1'b1, 24'h0, 24);
         chk("ctrl read", 24'h0a0064, rdat);
      end
      xfer(1'b0, 1'b0, 24'hc00064, 24);
      xfer(1'b1, 1'b0, 24'h5a3c01, 24);
      xfer(1'b1, 1'b0, 24'hffff00, 16);
      xfer(1'b1, 1'b1, 24'h0, 24);
      chk("zero coef", 24'h5a3c01, rdat);
      xfer(1'b0, 1'b0, 24'he00064, 24);
      xfer(1'b1, 1'b0, 24'h123456, 24);
      xfer(1'b1, 1'b0, 24'hffffff, 20);
      xfer(1'b1, 1'b1, 24'h0, 24);
      chk("full coef", 24'h123456, rdat);
      for (int w = 0; w < 2; w++) begin
         xfer(1'b0, 1'b0, w ? 24'h008064 : 24'h000064, 24);
         conv(24'habcdef);
         chk("conv ready", 24'h000000, ready_n);
         xfer(1'b1, 1'b1, 24'h0, w ? 24 : 16);
         chk("data", w ? 24'habcdef : 24'h00abcd, rdat);
         chk("ready after read", 24'h000001, ready_n);
      end
      xfer(1'b0, 1'b0, 24'ha00064, 24);
      n0 = slots;
      for (int k = 0; k < 5; k++) conv(24'h111111);
      chk("bg ready held", 24'h000001, ready_n);
      conv(24'h222222);
      chk("bg ready", 24'h000000, ready_n);
      chk("bg slots", 24'h000005, slots - n0);
      report_and_stop();
   end

endmodule : test_acc_control
